// [core/eci_defines.svh]
// Offsets, field positions and reset values of the ECC control block.
`ifndef ECI_DEFINES_SVH
`define ECI_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define ECI_ADR_CONFIG 8'h00
`define ECI_ADR_INJECT 8'h04
`define ECI_ADR_STATUS 8'h08

// ==========================================================
// Field positions
`define ECI_CFG_EN_BIT 0
`define ECI_INJ_ICACHE_TAG_INJECT_FIELD_LSB 0
`define ECI_INJ_ICACHE_DATA_INJECT_FIELD_LSB 2
`define ECI_INJ_RF_LSB 4
`define ECI_INJ_DCACHE_TAG_INJECT_FIELD_LSB 6
`define ECI_INJ_DATA_COUPLED_MEM_LSB 8
`define ECI_ST_CORR_LSB 0
`define ECI_ST_UNCORR_LSB 8
`define ECI_ST_HINT_BIT 16
`define ECI_ST_CNT_LSB 24

// ==========================================================
// Error sources
`define ECI_SRC_ICACHE_TAG_INJECT_FIELD 0
`define ECI_SRC_ICACHE_DATA_INJECT_FIELD 1
`define ECI_SRC_RF 2
`define ECI_SRC_DCACHE_TAG_INJECT_FIELD 3
`define ECI_SRC_DATA_COUPLED_MEM 4
`define ECI_SRC_INSTR_COUPLED_MEM 5
`define ECI_NSRC 6

// ==========================================================
// Reset values and fixed codes
`define ECI_CFG_EN_RST 1'h0
`define ECI_INJ_RST 2'h0
`define ECI_CNT_MAX 8'hff
`define ECI_RF_ZERO 5'h00

`endif

// [core/eci_pkg.sv]
// Types shared by the ECC control block.
package eci_pkg;
    typedef enum logic [1:0] {
        inject_none = 2'h0,
        inject_single = 2'h1,
        inject_double = 2'h2
    } eci_inject_type;
    typedef logic [7:0] eci_addr_type;
endpackage

// [core/eci_inject_field.sv]
// One self-clearing injection field and its bit flip pattern.
`timescale 1ns/1ps
`include "eci_defines.svh"
module eci_inject_field #(
    parameter int FLIP_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Software write of the field
    input wire logic wr_i,
    input wire logic [1:0] wr_val_i,
    // Qualified RAM write that takes the injection
    input wire logic trig_i,
    // Field state and flip pattern for the write in flight
    output eci_pkg::eci_inject_type field_o,
    output logic [FLIP_W-1:0] flip_o
);
    import eci_pkg::*;

    generate
        if (FLIP_W < 2) begin : g_chk
            $error("eci_inject_field needs FLIP_W of at least 2");
        end
    endgenerate

    eci_inject_type field_r;
    eci_inject_type field_nxt;

    // ==========================================================
    // Next field value
    always_comb begin
        field_nxt = field_r;
        if (wr_i) begin
            // The unused code arms nothing.
            case (wr_val_i)
                2'h1: field_nxt = inject_single;
                2'h2: field_nxt = inject_double;
                default: field_nxt = inject_none;
            endcase
        end else if (trig_i && field_r != inject_none) begin
            field_nxt = inject_none;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            field_r <= inject_none;
        end else begin
            field_r <= field_nxt;
        end
    end

    // ==========================================================
    // Flip pattern, applied to the stored word and check bits
    always_comb begin
        flip_o = '0;
        if (trig_i && field_r == inject_single) begin
            flip_o[0] = 1'b1;
        end else if (trig_i && field_r == inject_double) begin
            flip_o[1:0] = 2'h3;
        end
    end

    assign field_o = field_r;

    property p_self_clear;
        @(posedge clk_i) disable iff (rst_i)
        (trig_i && !wr_i && field_r != inject_none) |=> (field_r == inject_none);
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("field not cleared");

    property p_flip_count;
        @(posedge clk_i) disable iff (rst_i)
        trig_i |-> ($countones(flip_o) == ((field_r == inject_single) ? 1 :
                    (field_r == inject_double) ? 2 : 0));
    endproperty
    a_flip_count: assert property (p_flip_count) else $error("wrong flip count");
endmodule

// [core/eci_err_class.sv]
// Classifies one RAM's decoder result into correctable and uncorrectable events.
`timescale 1ns/1ps
`include "eci_defines.svh"
module eci_err_class (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Checking enable and line valid qualifier
    input wire logic en_i,
    input wire logic qual_i,
    // Decoder flags on the read in flight
    input wire logic sb_i,
    input wire logic db_i,
    // Registered event pulses
    output logic corr_o,
    output logic uncorr_o
);
    logic corr_r;
    logic corr_nxt;
    logic uncorr_r;
    logic uncorr_nxt;

    // ==========================================================
    // Event classification
    always_comb begin
        corr_nxt = en_i && qual_i && sb_i && !db_i;
        uncorr_nxt = en_i && qual_i && db_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            corr_r <= 1'b0;
            uncorr_r <= 1'b0;
        end else begin
            corr_r <= corr_nxt;
            uncorr_r <= uncorr_nxt;
        end
    end

    assign corr_o = corr_r;
    assign uncorr_o = uncorr_r;

    property p_off_silent;
        @(posedge clk_i) disable iff (rst_i)
        (!en_i || !qual_i) |=> !(corr_o || uncorr_o);
    endproperty
    a_off_silent: assert property (p_off_silent) else $error("event while off");

    property p_double_flags;
        @(posedge clk_i) disable iff (rst_i)
        (en_i && qual_i && db_i) |=> (uncorr_o && !corr_o);
    endproperty
    a_double_flags: assert property (p_double_flags) else $error("double not uncorr");
endmodule

// [core/eci_ctrl.sv]
// ECC control, error injection and event reporting with a Wishbone register slave.
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "eci_defines.svh"
module eci_ctrl #(
    parameter int TAG_W = 24,
    parameter int DATA_W = 32,
    parameter int RF_W = 32,
    parameter int DCACHE_TAG_INJECT_FIELD_W = 24,
    parameter int DATA_COUPLED_MEM_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire eci_pkg::eci_addr_type wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core state
    input wire logic in_handler_i,
    // RAM write strobes that may take an injection
    input wire logic ic_fill_tag_we_i,
    input wire logic ic_fill_data_we_i,
    input wire logic rf_we_i,
    input wire logic [4:0] rf_waddr_i,
    input wire logic dc_tag_dirty_we_i,
    input wire logic data_coupled_mem_we_i,
    // Flip patterns applied to those writes
    output logic [TAG_W-1:0] ic_tag_flip_o,
    output logic [DATA_W-1:0] ic_data_flip_o,
    output logic [RF_W-1:0] rf_flip_o,
    output logic [DCACHE_TAG_INJECT_FIELD_W-1:0] dc_tag_flip_o,
    output logic [DATA_COUPLED_MEM_W-1:0] data_coupled_mem_flip_o,
    // Decoder flags from the RAM reads
    input wire logic ic_line_valid_i,
    input wire logic ic_tag_sb_i,
    input wire logic ic_tag_db_i,
    input wire logic ic_data_sb_i,
    input wire logic ic_data_db_i,
    input wire logic rf_a_sb_i,
    input wire logic rf_a_db_i,
    input wire logic dc_tag_sb_i,
    input wire logic dc_tag_db_i,
    input wire logic data_coupled_mem_sb_i,
    input wire logic data_coupled_mem_db_i,
    input wire logic instr_coupled_mem_sb_i,
    input wire logic instr_coupled_mem_db_i,
    // Checking, correction and exception outputs
    output logic ecc_check_en_o,
    output logic instr_coupled_mem_fix_we_o,
    output logic ecc_exc_o,
    output logic [12:0] ecc_event_o
);
    import eci_pkg::*;

    generate
        if (TAG_W < 2 || DATA_W < 2 || RF_W < 2 || DCACHE_TAG_INJECT_FIELD_W < 2 || DATA_COUPLED_MEM_W < 2) begin : g_chk
            $error("eci_ctrl flip widths must be at least 2");
        end
    endgenerate

    // ==========================================================
    // Bus decode
    logic acc;
    logic wr_cfg;
    logic wr_inj_lo;
    logic wr_inj_hi;
    logic wr_st;
    logic ack_r;
    logic ack_nxt;
    logic [31:0] dat_r;
    logic [31:0] dat_nxt;

    // A request is taken in the cycle its strobe is seen with no ack pending.
    assign acc = wb_cyc_i && wb_stb_i && !ack_r;

    always_comb begin
        wr_cfg = 1'b0;
        wr_inj_lo = 1'b0;
        wr_inj_hi = 1'b0;
        wr_st = 1'b0;
        if (acc && wb_we_i && wb_adr_i == `ECI_ADR_CONFIG) begin
            wr_cfg = wb_sel_i[0];
        end else if (acc && wb_we_i && wb_adr_i == `ECI_ADR_INJECT) begin
            wr_inj_lo = wb_sel_i[0];
            wr_inj_hi = wb_sel_i[1];
        end else if (acc && wb_we_i && wb_adr_i == `ECI_ADR_STATUS) begin
            wr_st = 1'b1;
        end
    end

    // ==========================================================
    // Enable register
    logic en_r;
    logic en_nxt;

    always_comb begin
        en_nxt = en_r;
        if (wr_cfg) begin
            en_nxt = wb_dat_i[`ECI_CFG_EN_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= `ECI_CFG_EN_RST;
        end else begin
            en_r <= en_nxt;
        end
    end

    // Only detection is gated; the encoders store check bits on every
    // write, so re-enabling or a plain rewrite of any RAM leaves it clean.
    assign ecc_check_en_o = en_r;

    // ==========================================================
    // Injection fields
    eci_inject_type f_icache_tag_inject_field;
    eci_inject_type f_icache_data_inject_field;
    eci_inject_type f_rf;
    eci_inject_type f_dcache_tag_inject_field;
    eci_inject_type f_data_coupled_mem;
    logic rf_trig;

    assign rf_trig = rf_we_i && (rf_waddr_i != `ECI_RF_ZERO);

    eci_inject_field #(.FLIP_W(TAG_W)) u_inj_icache_tag_inject_field (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_inj_lo),
        .wr_val_i(wb_dat_i[`ECI_INJ_ICACHE_TAG_INJECT_FIELD_LSB +: 2]),
        .trig_i(ic_fill_tag_we_i),
        .field_o(f_icache_tag_inject_field),
        .flip_o(ic_tag_flip_o)
    );

    eci_inject_field #(.FLIP_W(DATA_W)) u_inj_icache_data_inject_field (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_inj_lo),
        .wr_val_i(wb_dat_i[`ECI_INJ_ICACHE_DATA_INJECT_FIELD_LSB +: 2]),
        .trig_i(ic_fill_data_we_i),
        .field_o(f_icache_data_inject_field),
        .flip_o(ic_data_flip_o)
    );

    eci_inject_field #(.FLIP_W(RF_W)) u_inj_rf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_inj_lo),
        .wr_val_i(wb_dat_i[`ECI_INJ_RF_LSB +: 2]),
        .trig_i(rf_trig),
        .field_o(f_rf),
        .flip_o(rf_flip_o)
    );

    eci_inject_field #(.FLIP_W(DCACHE_TAG_INJECT_FIELD_W)) u_inj_dcache_tag_inject_field (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_inj_lo),
        .wr_val_i(wb_dat_i[`ECI_INJ_DCACHE_TAG_INJECT_FIELD_LSB +: 2]),
        .trig_i(dc_tag_dirty_we_i),
        .field_o(f_dcache_tag_inject_field),
        .flip_o(dc_tag_flip_o)
    );

    // The instruction memory shares this RAM, so this is its only way in.
    eci_inject_field #(.FLIP_W(DATA_COUPLED_MEM_W)) u_inj_data_coupled_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(wr_inj_hi),
        .wr_val_i(wb_dat_i[`ECI_INJ_DATA_COUPLED_MEM_LSB +: 2]),
        .trig_i(data_coupled_mem_we_i),
        .field_o(f_data_coupled_mem),
        .flip_o(data_coupled_mem_flip_o)
    );

    // ==========================================================
    // Error classification
    logic [`ECI_NSRC-1:0] sb_v;
    logic [`ECI_NSRC-1:0] db_v;
    logic [`ECI_NSRC-1:0] qual_v;
    logic [`ECI_NSRC-1:0] corr_v;
    logic [`ECI_NSRC-1:0] uncorr_v;

    assign sb_v = {instr_coupled_mem_sb_i, data_coupled_mem_sb_i, dc_tag_sb_i, rf_a_sb_i, ic_data_sb_i, ic_tag_sb_i};
    assign db_v = {instr_coupled_mem_db_i, data_coupled_mem_db_i, dc_tag_db_i, rf_a_db_i, ic_data_db_i, ic_tag_db_i};
    // Only instruction cache reads carry a line valid qualifier.
    assign qual_v = {4'hf, ic_line_valid_i, ic_line_valid_i};

    genvar gi;
    generate
        for (gi = 0; gi < `ECI_NSRC; gi++) begin : g_cls
            eci_err_class u_cls (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .en_i(en_r),
                .qual_i(qual_v[gi]),
                .sb_i(sb_v[gi]),
                .db_i(db_v[gi]),
                .corr_o(corr_v[gi]),
                .uncorr_o(uncorr_v[gi])
            );
        end
    endgenerate

    // ==========================================================
    // Exception, loop hint and correction write
    logic hq_r;
    logic hq_nxt;
    logic hint;

    always_comb begin
        hq_nxt = in_handler_i;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hq_r <= 1'b0;
        end else begin
            hq_r <= hq_nxt;
        end
    end

    // An uncorrectable read with checking on and, for the instruction cache, a valid line raises the exception a cycle later, inside a handler too.
    assign ecc_exc_o = |uncorr_v;
    assign hint = ecc_exc_o && hq_r;
    assign instr_coupled_mem_fix_we_o = corr_v[`ECI_SRC_INSTR_COUPLED_MEM];
    assign ecc_event_o = {hint, uncorr_v, corr_v};

    // ==========================================================
    // Sticky status and uncorrectable count
    logic [`ECI_NSRC-1:0] sc_r;
    logic [`ECI_NSRC-1:0] sc_nxt;
    logic [`ECI_NSRC-1:0] su_r;
    logic [`ECI_NSRC-1:0] su_nxt;
    logic sh_r;
    logic sh_nxt;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    always_comb begin
        sc_nxt = sc_r;
        su_nxt = su_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        if (wr_st && wb_sel_i[0]) begin
            sc_nxt = sc_nxt & ~wb_dat_i[`ECI_ST_CORR_LSB +: `ECI_NSRC];
        end
        if (wr_st && wb_sel_i[1]) begin
            su_nxt = su_nxt & ~wb_dat_i[`ECI_ST_UNCORR_LSB +: `ECI_NSRC];
        end
        if (wr_st && wb_sel_i[2] && wb_dat_i[`ECI_ST_HINT_BIT]) begin
            sh_nxt = 1'b0;
        end
        if (wr_st && wb_sel_i[3]) begin
            cnt_nxt = 8'h00;
        end
        // New events win over a clear in the same cycle.
        sc_nxt = sc_nxt | corr_v;
        su_nxt = su_nxt | uncorr_v;
        sh_nxt = sh_nxt | hint;
        // Counting from the cleared value lets an event in the clear cycle survive.
        if (ecc_exc_o && cnt_nxt != `ECI_CNT_MAX) begin
            cnt_nxt = cnt_nxt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sc_r <= '0;
            su_r <= '0;
            sh_r <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            sc_r <= sc_nxt;
            su_r <= su_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ==========================================================
    // Read data and acknowledge
    always_comb begin
        ack_nxt = acc;
        dat_nxt = 32'h0000_0000;
        if (acc && !wb_we_i && wb_adr_i == `ECI_ADR_CONFIG) begin
            dat_nxt[`ECI_CFG_EN_BIT] = en_r;
        end else if (acc && !wb_we_i && wb_adr_i == `ECI_ADR_INJECT) begin
            dat_nxt[`ECI_INJ_ICACHE_TAG_INJECT_FIELD_LSB +: 2] = f_icache_tag_inject_field;
            dat_nxt[`ECI_INJ_ICACHE_DATA_INJECT_FIELD_LSB +: 2] = f_icache_data_inject_field;
            dat_nxt[`ECI_INJ_RF_LSB +: 2] = f_rf;
            dat_nxt[`ECI_INJ_DCACHE_TAG_INJECT_FIELD_LSB +: 2] = f_dcache_tag_inject_field;
            dat_nxt[`ECI_INJ_DATA_COUPLED_MEM_LSB +: 2] = f_data_coupled_mem;
        end else if (acc && !wb_we_i && wb_adr_i == `ECI_ADR_STATUS) begin
            dat_nxt[`ECI_ST_CORR_LSB +: `ECI_NSRC] = sc_r;
            dat_nxt[`ECI_ST_UNCORR_LSB +: `ECI_NSRC] = su_r;
            dat_nxt[`ECI_ST_HINT_BIT] = sh_r;
            dat_nxt[`ECI_ST_CNT_LSB +: 8] = cnt_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // ==========================================================
    // Checks
    sequence s_db_read;
        en_r && rf_a_db_i;
    endsequence

    sequence s_exc_hint;
        ecc_exc_o && (ecc_event_o[12] == $past(in_handler_i));
    endsequence

    property p_reset_off;
        @(posedge clk_i) rst_i |=> !ecc_check_en_o;
    endproperty
    a_reset_off: assert property (p_reset_off) else $error("checking on after reset");

    property p_disable;
        @(posedge clk_i) disable iff (rst_i)
        (wr_cfg && !wb_dat_i[`ECI_CFG_EN_BIT]) |=> !ecc_check_en_o ##1 !ecc_exc_o;
    endproperty
    a_disable: assert property (p_disable) else $error("disable not taken");

    property p_rf_repeat;
        @(posedge clk_i) disable iff (rst_i || wr_cfg)
        s_db_read |=> s_exc_hint;
    endproperty
    a_rf_repeat: assert property (p_rf_repeat) else $error("no exception on rf read");

    property p_exc_cause;
        @(posedge clk_i) disable iff (rst_i)
        ecc_exc_o |-> $past(en_r) && ($past(db_v) != '0);
    endproperty
    a_exc_cause: assert property (p_exc_cause) else $error("exception without cause");

    property p_rf_zero;
        @(posedge clk_i) disable iff (rst_i)
        (rf_we_i && rf_waddr_i == `ECI_RF_ZERO) |-> (rf_flip_o == '0);
    endproperty
    a_rf_zero: assert property (p_rf_zero) else $error("register zero injected");

    property p_instr_coupled_mem_fix;
        @(posedge clk_i) disable iff (rst_i)
        instr_coupled_mem_fix_we_o |-> $past(instr_coupled_mem_sb_i) && !$past(instr_coupled_mem_db_i) && $past(en_r);
    endproperty
    a_instr_coupled_mem_fix: assert property (p_instr_coupled_mem_fix) else $error("instr_coupled_mem write without fix");

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");

    property p_icache_tag_inject_field_once;
        @(posedge clk_i) disable iff (rst_i)
        (ic_fill_tag_we_i && !wr_inj_lo && f_icache_tag_inject_field != inject_none) |=>
            (ic_fill_tag_we_i |-> ic_tag_flip_o == '0);
    endproperty
    a_icache_tag_inject_field_once: assert property (p_icache_tag_inject_field_once) else $error("tag injected twice");
endmodule

// [tb/tb_eci_ctrl.sv]
// Self-checking bench for the ECC control block over its Wishbone registers.
`timescale 1ns/1ps
`include "eci_defines.svh"
module tb_eci_ctrl;
    import eci_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hnd = 1'b0, valid = 1'b1;
    eci_addr_type adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000, dat_o, rd;
    logic ack, chk_en, fix_we, exc;
    logic [12:0] ev_o;
    logic [4:0] stbv = 5'h00, waddr = 5'h00;
    logic [11:0] flg = 12'h000;
    logic [23:0] f_icache_tag_inject_field, f_dcache_tag_inject_field;
    logic [31:0] f_icache_data_inject_field, f_rf, f_data_coupled_mem;
    logic [143:0] flips;
    int n_errors = 0;
    int n_compared = 0;
    assign flips = {f_data_coupled_mem, f_dcache_tag_inject_field, f_rf, f_icache_data_inject_field, f_icache_tag_inject_field};
    eci_ctrl i_eci_ctrl (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .in_handler_i(hnd), .ic_fill_tag_we_i(stbv[0]),
        .ic_fill_data_we_i(stbv[1]), .rf_we_i(stbv[2]), .rf_waddr_i(waddr),
        .dc_tag_dirty_we_i(stbv[3]), .data_coupled_mem_we_i(stbv[4]), .ic_tag_flip_o(f_icache_tag_inject_field),
        .ic_data_flip_o(f_icache_data_inject_field), .rf_flip_o(f_rf), .dc_tag_flip_o(f_dcache_tag_inject_field),
        .data_coupled_mem_flip_o(f_data_coupled_mem), .ic_line_valid_i(valid), .ic_tag_sb_i(flg[0]),
        .ic_tag_db_i(flg[1]), .ic_data_sb_i(flg[2]), .ic_data_db_i(flg[3]),
        .rf_a_sb_i(flg[4]), .rf_a_db_i(flg[5]), .dc_tag_sb_i(flg[6]), .dc_tag_db_i(flg[7]),
        .data_coupled_mem_sb_i(flg[8]), .data_coupled_mem_db_i(flg[9]), .instr_coupled_mem_sb_i(flg[10]), .instr_coupled_mem_db_i(flg[11]),
        .ecc_check_en_o(chk_en), .instr_coupled_mem_fix_we_o(fix_we), .ecc_exc_o(exc), .ecc_event_o(ev_o));
    // ==========================================================
    // Clock, check and closing report
    initial begin
        forever #10 clk_i = ~clk_i;
    end
    task automatic check(input string nm, input logic [143:0] seen, input logic [143:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========================================================
    // Bus cycle, held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; dat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        r = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n == 20) begin
            n_errors++;
            results();
        end
    endtask
    // Pulses decoder flags for one cycle and checks the registered answer.
    task automatic det(input logic [11:0] f, input logic v, input logic h,
                       input logic [12:0] ev, input logic ex, input logic fx);
        @(posedge clk_i);
        flg <= f; valid <= v; hnd <= h;
        @(posedge clk_i);
        flg <= 12'h000; hnd <= 1'b0; valid <= 1'b1;
        #1;
        check("event", ev_o, ev);
        check("exception", exc, ex);
        check("instr_coupled_mem fix", fix_we, fx);
    endtask
    // Pulses one RAM write strobe and checks the flip masks in that cycle.
    task automatic strobe(input int i, input logic [4:0] wa, input logic [143:0] exp);
        @(posedge clk_i);
        stbv <= 5'h01 << i; waddr <= wa;
        #1;
        check("flip", flips, exp);
        @(posedge clk_i);
        stbv <= 5'h00;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        int offs[5];
        offs = '{0, 24, 56, 88, 112};
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        check("check_en reset", chk_en, 1'b0);
        wb(1'b0, `ECI_ADR_CONFIG, 4'hf, 32'h0, rd);
        check("config reset", rd, 32'h0000_0000);
        wb(1'b0, `ECI_ADR_INJECT, 4'hf, 32'h0, rd);
        check("inject reset", rd, 32'h0000_0000);
        det(12'h020, 1'b1, 1'b0, 13'h0000, 1'b0, 1'b0);
        // Software start up: every register but zero is written, cache lines left invalid.
        for (int r = 1; r < 32; r++) begin
            strobe(2, 5'(r), 144'h0);
        end
        det(12'h003, 1'b0, 1'b0, 13'h0000, 1'b0, 1'b0);
        wb(1'b1, `ECI_ADR_CONFIG, 4'hf, 32'h0000_0001, rd);
        #1;
        check("check_en on", chk_en, 1'b1);
        wb(1'b1, 8'hf0, 4'hf, 32'h0000_0000, rd);
        wb(1'b0, 8'hfc, 4'hf, 32'h0, rd);
        check("unmapped read", rd, 32'h0000_0000);
        wb(1'b0, `ECI_ADR_CONFIG, 4'hf, 32'h0, rd);
        check("config kept", rd, 32'h0000_0001);
        wb(1'b1, `ECI_ADR_INJECT, 4'hf, 32'h0000_0003, rd);
        wb(1'b0, `ECI_ADR_INJECT, 4'hf, 32'h0, rd);
        check("inject code 3", rd, 32'h0000_0000);
        for (int i = 0; i < 5; i++) begin
            for (int v = 1; v < 3; v++) begin
                wb(1'b1, `ECI_ADR_INJECT, 4'h3, 32'(v) << (2 * i), rd);
                wb(1'b0, `ECI_ADR_INJECT, 4'hf, 32'h0, rd);
                check("inject armed", rd, 32'(v) << (2 * i));
                if (i == 2) strobe(i, 5'h00, 144'h0);
                strobe(i, 5'h03, 144'(v == 1 ? 1 : 3) << offs[i]);
                strobe(i, 5'h03, 144'h0);
                wb(1'b0, `ECI_ADR_INJECT, 4'hf, 32'h0, rd);
                check("inject cleared", rd, 32'h0000_0000);
            end
        end
        for (int s = 0; s < 6; s++) begin
            for (int d = 0; d < 2; d++) begin
                det(12'h001 << (2 * s + d), 1'b1, 1'b0,
                    d ? 13'h0001 << (6 + s) : 13'h0001 << s,
                    d[0], s == 5 && d == 0);
            end
        end
        det(12'h003, 1'b0, 1'b0, 13'h0000, 1'b0, 1'b0);
        det(12'h00c, 1'b0, 1'b0, 13'h0000, 1'b0, 1'b0);
        wb(1'b1, `ECI_ADR_STATUS, 4'hf, 32'hffff_ffff, rd);
        det(12'h020, 1'b1, 1'b0, 13'h0100, 1'b1, 1'b0);
        // An uncorrectable register read from inside the handler.
        det(12'h020, 1'b1, 1'b1, 13'h1100, 1'b1, 1'b0);
        wb(1'b0, `ECI_ADR_STATUS, 4'hf, 32'h0, rd);
        check("status", rd, 32'h0201_0400);
        wb(1'b1, `ECI_ADR_CONFIG, 4'h1, 32'h0000_0000, rd);
        #1;
        check("check_en off", chk_en, 1'b0);
        det(12'h020, 1'b1, 1'b1, 13'h0000, 1'b0, 1'b0);
        // Injection runs with checking enabled again.
        wb(1'b1, `ECI_ADR_CONFIG, 4'h1, 32'h0000_0001, rd);
        wb(1'b1, `ECI_ADR_INJECT, 4'h3, 32'h0000_0200, rd);
        strobe(4, 5'h00, 144'h3 << 112);
        results();
    end
endmodule
